/* rtl/adcct_defines.svh */
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCCT_DEFINES_SVH
`define ADCCT_DEFINES_SVH

// register offsets (index on the plain register port)
`define ADCCT_OFS_CTRL_ONE   4'h0
`define ADCCT_OFS_CTRL_TWO   4'h1
`define ADCCT_OFS_CTRL_THREE 4'h2
`define ADCCT_OFS_STATUS     4'h3
`define ADCCT_OFS_MASK       4'h4
`define ADCCT_OFS_RESULT_A   4'h5
`define ADCCT_OFS_RESULT_B   4'h6
`define ADCCT_OFS_STATE      4'h7

// converter_control_one fields
`define ADCCT_CHAN_LSB  0
`define ADCCT_CHAN_MSB  3
`define ADCCT_CONV_LSB  4
`define ADCCT_CONV_MSB  7
`define ADCCT_ACQ_LSB   8
`define ADCCT_ACQ_MSB   11

// converter_control_two fields
`define ADCCT_EVA_EN_BIT 0
`define ADCCT_EVB_EN_BIT 1
`define ADCCT_EXT_EN_BIT 2
`define ADCCT_SW_START_BIT 15

// converter_control_three fields
`define ADCCT_MODE_BIT   0
`define ADCCT_DIV_LSB    1
`define ADCCT_DIV_MSB    4
`define ADCCT_POWER_BIT  5
`define ADCCT_BGREF_LSB  6
`define ADCCT_BGREF_MSB  7

// status and mask bits
`define ADCCT_ST_RES_A   0
`define ADCCT_ST_RES_B   1
`define ADCCT_ST_OVERRUN 2

// reset values
`define ADCCT_RST_CTRL_ONE   16'h0000
`define ADCCT_RST_CTRL_TWO   16'h0000
`define ADCCT_RST_CTRL_THREE 16'h0000
`define ADCCT_RST_MASK       3'h0

// timing counts in converter-clock half periods
`define ADCCT_TRIG_HALF   5'h05
`define ADCCT_LAT_A_HALF  8
`define ADCCT_LAT_B_HALF  10
`define ADCCT_GAP_SEQ_HALF 5'h02
`define ADCCT_GAP_SIM_HALF 5'h04
// system clocks from result write to flag
`define ADCCT_FLAG_DELAY  2

`endif

/* rtl/adcct_pkg.sv */
// types shared by the converter control modules
package adcct_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_HOLD, ST_GAP} adcct_state_e;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
    logic       level;
  } adcct_div_s;

  typedef struct packed {
    logic [15:0]  ctrl_one;
    logic [15:0]  ctrl_two;
    logic [15:0]  ctrl_three;
    logic [2:0]   status;
    logic [2:0]   mask;
    logic [11:0]  result_a;
    logic [11:0]  result_b;
    logic [15:0]  rdata;
    adcct_state_e state;
    logic [4:0]   hcnt;
    logic [3:0]   left;
    logic         sh;
    logic [9:0]   dline;
    logic [1:0]   flag_a;
    logic [1:0]   flag_b;
    logic [5:0]   ph;
  } adcct_ctl_s;

endpackage : adcct_pkg

/* rtl/adcct_clkdiv.sv */
// converter clock divider: half-period enable pulses and the clock level
module adcct_clkdiv
  import adcct_pkg::*;
#(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // half period in system clocks, minus one
  input  wire logic [W-1:0] half_count,
  // outputs
  output logic              half_tick,
  output logic              converter_clock
);

  adcct_div_s s;
  adcct_div_s n;

  // count system clocks; every half period toggles the level and pulses the enable
  always_comb begin
    n      = s;
    n.tick = 1'b0;
    if (s.cnt >= half_count) begin
      n.cnt   = 4'h0;
      n.tick  = 1'b1;
      n.level = ~s.level;
    end else begin
      n.cnt = s.cnt + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign half_tick       = s.tick;
  assign converter_clock = s.level;

endmodule : adcct_clkdiv

/* rtl/adcct_ctrl.sv */
// converter control: power bits, triggers, sample/hold timing, result writes, flags
//
// How it works
// - one write may clear band-gap, reference and power bits together.
// - mode bit 0 samples one channel, 1 samples a channel pair.
// - sixteen selectable input channels, sampled singly or as a pair.
// - conversion starts on event unit, software or external start trigger.
// - sequential mode converts selected channel once per hold pulse, sampled at fall.
// - hold pulse lasts one plus acquisition setting converter clocks, setting in bits 8-11.
// - sampling begins two and a half converter clocks after the trigger.
// - sequential result lands four clocks after sampling, then every two plus setting.
// - simultaneous mode converts one pair per hold pulse, both sampled at fall.
// - pair results land at four and five clocks, then every three plus setting.
// - interrupt flags rise a few system clocks after the result write.
// - twelve-bit results through a four-stage pipeline; conversions overlap.
//
// Local design decisions: the register addresses and strobed register access.
`include "adcct_defines.svh"

module adcct_ctrl
  import adcct_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [15:0]      reg_rdata,
  // start triggers
  input  wire logic [1:0]  event_manager_units,
  input  wire logic        external_start_conversion,
  // analog core
  output logic [1:0]       bandgap_reference_enable,
  output logic             converter_power_on,
  output logic             converter_clock,
  output logic             sample_hold,
  output logic [3:0]       channel_select,
  output logic             sampling_mode_select,
  input  wire logic [11:0] conv_data_a,
  input  wire logic [11:0] conv_data_b,
  // interrupt
  output logic             interrupt
);

  adcct_ctl_s s;
  adcct_ctl_s n;
  logic       h;
  logic       trig;
  logic       write_a;
  logic       write_b;
  logic [2:0] set_bits;
  logic [2:0] clr_bits;
  logic [5:0] hold_half;
  logic [4:0] gap_half;

  // half-period enables of the converter clock, rate from control three
  adcct_clkdiv #(
    .W (4)
  ) u_div (
    .clock           (clock),
    .reset           (reset),
    .half_count      (s.ctrl_three[`ADCCT_DIV_MSB:`ADCCT_DIV_LSB]),
    .half_tick       (h),
    .converter_clock (converter_clock)
  );

  // hold pulse in half periods: 2*(1+acq); six bits so that 32 half periods do not wrap
  assign hold_half = {1'b0, s.ctrl_one[`ADCCT_ACQ_MSB:`ADCCT_ACQ_LSB], 1'b0} + 6'h02;
  assign gap_half  = s.ctrl_three[`ADCCT_MODE_BIT] ? `ADCCT_GAP_SIM_HALF
                                                    : `ADCCT_GAP_SEQ_HALF;

  // any enabled start source; ignored while the converter is powered down
  assign trig = s.ctrl_three[`ADCCT_POWER_BIT] &&
                ((reg_write && reg_addr == `ADCCT_OFS_CTRL_TWO &&
                  reg_wdata[`ADCCT_SW_START_BIT]) ||
                 (event_manager_units[0] && s.ctrl_two[`ADCCT_EVA_EN_BIT]) ||
                 (event_manager_units[1] && s.ctrl_two[`ADCCT_EVB_EN_BIT]) ||
                 (external_start_conversion && s.ctrl_two[`ADCCT_EXT_EN_BIT]));

  // result writes: taps of the sample delay line, B only in simultaneous mode
  assign write_a = h && s.dline[`ADCCT_LAT_A_HALF-1];
  assign write_b = h && s.dline[`ADCCT_LAT_B_HALF-1] &&
                   s.ctrl_three[`ADCCT_MODE_BIT];

  // flags come from the delayed write strobes; overrun is a trigger during a run
  assign set_bits = {trig && s.state != ST_IDLE,
                     s.flag_b[`ADCCT_FLAG_DELAY-1],
                     s.flag_a[`ADCCT_FLAG_DELAY-1]};
  assign clr_bits = (reg_write && reg_addr == `ADCCT_OFS_STATUS) ? reg_wdata[2:0] : 3'h0;

  // next state of registers, sequencer, delay line and flags
  always_comb begin
    n          = s;
    n.rdata    = 16'h0000;
    // register writes
    if (reg_write) begin
      unique case (reg_addr)
        `ADCCT_OFS_CTRL_ONE: begin
          n.ctrl_one = {4'h0, reg_wdata[11:0]};
        end
        `ADCCT_OFS_CTRL_TWO: begin
          n.ctrl_two = {13'h0000, reg_wdata[2:0]}; // start bit is write-only
        end
        `ADCCT_OFS_CTRL_THREE: begin
          n.ctrl_three = {8'h00, reg_wdata[7:0]};
        end
        `ADCCT_OFS_MASK: begin
          n.mask = reg_wdata[2:0];
        end
        default: begin
        end
      endcase
    end
    // set wins over a write-one clear in the same cycle
    n.status = (s.status & ~clr_bits) | set_bits;
    // read data stand only in the cycle after the strobe
    if (reg_read) begin
      unique case (reg_addr)
        `ADCCT_OFS_CTRL_ONE:   n.rdata = s.ctrl_one;
        `ADCCT_OFS_CTRL_TWO:   n.rdata = s.ctrl_two;
        `ADCCT_OFS_CTRL_THREE: n.rdata = s.ctrl_three;
        `ADCCT_OFS_STATUS:     n.rdata = {13'h0000, s.status};
        `ADCCT_OFS_MASK:       n.rdata = {13'h0000, s.mask};
        `ADCCT_OFS_RESULT_A:   n.rdata = {4'h0, s.result_a};
        `ADCCT_OFS_RESULT_B:   n.rdata = {4'h0, s.result_b};
        `ADCCT_OFS_STATE:      n.rdata = {14'h0000, s.sh, s.state != ST_IDLE};
        default:               n.rdata = 16'h0000;
      endcase
    end
    // results captured from the pipeline output on the write strobes
    if (write_a) begin
      n.result_a = conv_data_a;
    end
    if (write_b) begin
      n.result_b = conv_data_b;
    end
    n.flag_a = {s.flag_a[0], write_a};
    n.flag_b = {s.flag_b[0], write_b};
    // sample delay line advances each half period; holds several samples in flight
    if (h) begin
      n.dline = {s.dline[8:0], 1'b0};
    end
    // sequencer, counted in converter-clock half periods
    unique case (s.state)
      ST_IDLE: begin
        if (trig) begin
          n.state = ST_DELAY;
          n.hcnt  = `ADCCT_TRIG_HALF - 5'h01;
          n.left  = s.ctrl_one[`ADCCT_CONV_MSB:`ADCCT_CONV_LSB];
        end
      end
      ST_DELAY: begin
        if (h) begin
          if (s.hcnt == 5'h00) begin
            n.state = ST_HOLD;
            n.sh    = 1'b1;
            n.hcnt  = 5'(hold_half - 6'h01);
          end else begin
            n.hcnt = s.hcnt - 5'h01;
          end
        end
      end
      ST_HOLD: begin
        if (h) begin
          if (s.hcnt == 5'h00) begin
            // falling edge of the hold pulse is the sampling instant
            n.sh       = 1'b0;
            n.dline[0] = 1'b1;
            if (s.left == 4'h0) begin
              n.state = ST_IDLE;
            end else begin
              n.state = ST_GAP;
              n.left  = s.left - 4'h1;
              n.hcnt  = gap_half - 5'h01;
            end
          end else begin
            n.hcnt = s.hcnt - 5'h01;
          end
        end
      end
      ST_GAP: begin
        if (h) begin
          if (s.hcnt == 5'h00) begin
            n.state = ST_HOLD;
            n.sh    = 1'b1;
            n.hcnt  = 5'(hold_half - 6'h01);
          end else begin
            n.hcnt = s.hcnt - 5'h01;
          end
        end
      end
    endcase
    // powering down aborts a run; samples in flight are dropped too
    if (!s.ctrl_three[`ADCCT_POWER_BIT]) begin
      n.state = ST_IDLE;
      n.sh    = 1'b0;
      n.dline = 10'h000;
    end
    // half periods spent in the current state, read by the checks below
    n.ph = (n.state != s.state) ? 6'h00 : s.ph + {5'h00, h};
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s            <= '0;
      s.ctrl_one   <= `ADCCT_RST_CTRL_ONE;
      s.ctrl_two   <= `ADCCT_RST_CTRL_TWO;
      s.ctrl_three <= `ADCCT_RST_CTRL_THREE;
      s.mask       <= `ADCCT_RST_MASK;
      s.state      <= ST_IDLE;
    end else begin
      s <= n;
    end
  end

  // outputs to the analog core; waits are left to software
  assign bandgap_reference_enable = s.ctrl_three[`ADCCT_BGREF_MSB:`ADCCT_BGREF_LSB];
  assign converter_power_on       = s.ctrl_three[`ADCCT_POWER_BIT];
  assign sampling_mode_select     = s.ctrl_three[`ADCCT_MODE_BIT];
  // in pair mode only the low three bits pick A0/B0..A7/B7
  assign channel_select = s.ctrl_three[`ADCCT_MODE_BIT] ?
                          {1'b0, s.ctrl_one[2:0]} :
                          s.ctrl_one[`ADCCT_CHAN_MSB:`ADCCT_CHAN_LSB];
  assign sample_hold    = s.sh;
  assign reg_rdata      = s.rdata;
  assign interrupt      = |(s.status & s.mask);

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence seq_write_a;
    write_a;
  endsequence

  sequence seq_flag_a;
    ##`ADCCT_FLAG_DELAY 1'b1 ##1 s.status[`ADCCT_ST_RES_A];
  endsequence

  sequence seq_hold_end;
    s.state == ST_HOLD && h && s.hcnt == 5'h00;
  endsequence

  AST_TRIG_DELAY: assert property (
    $rose(sample_hold) && $past(s.state) == ST_DELAY |-> $past(s.ph) == 6'd4)
    else $error("hold pulse did not start five half periods after trigger");

  AST_HOLD_WIDTH: assert property (
    seq_hold_end |-> s.ph == hold_half - 6'd1)
    else $error("hold pulse width differs from one plus acquisition setting");

  AST_GAP_WIDTH: assert property (
    $rose(sample_hold) && $past(s.state) == ST_GAP |->
      $past(s.ph) == (sampling_mode_select ? 6'd3 : 6'd1))
    else $error("gap between hold pulses wrong for the mode");

  AST_SAMPLE_AT_FALL: assert property (
    seq_hold_end |=> !sample_hold && s.dline[0])
    else $error("sample not taken at hold pulse fall");

  AST_RESULT_A: assert property (
    seq_write_a |=> s.result_a == $past(conv_data_a))
    else $error("result A not written from pipeline output");

  AST_RESULT_B: assert property (
    write_b |=> s.result_b == $past(conv_data_b) ##0 sampling_mode_select)
    else $error("result B write wrong");

  AST_FLAG_A: assert property (
    seq_write_a |-> seq_flag_a)
    else $error("result flag A not set after write");

  AST_START: assert property (
    trig && s.state == ST_IDLE |=> s.state == ST_DELAY && !sample_hold)
    else $error("trigger did not start a conversion");

  AST_POWER_OFF: assert property (
    !converter_power_on |=> s.state == ST_IDLE && !sample_hold [*2])
    else $error("converter ran while powered down");

  // refused starts, flag sources and the shape of the pulse between its edges
  sequence seq_flag_b;
    ##`ADCCT_FLAG_DELAY 1'b1 ##1 s.status[`ADCCT_ST_RES_B];
  endsequence

  sequence seq_busy_trig;
    trig && s.state != ST_IDLE;
  endsequence

  // a power-off mid-pulse drops the hold level at once, so it is left out here
  sequence seq_hold_mid;
    s.state == ST_HOLD && converter_power_on && !(h && s.hcnt == 5'h00);
  endsequence

  AST_FLAG_B: assert property (
    write_b |-> seq_flag_b)
    else $error("result flag B not set after write");

  AST_OVERRUN: assert property (
    seq_busy_trig |=> s.status[`ADCCT_ST_OVERRUN])
    else $error("start during a run not flagged as overrun");

  AST_BUSY_REFUSED: assert property (
    trig && (s.state == ST_HOLD || s.state == ST_GAP) |=> s.state != ST_DELAY)
    else $error("start during a run restarted the sequencer");

  AST_HOLD_STEADY: assert property (
    seq_hold_mid |=> sample_hold)
    else $error("hold pulse dropped before its count ran out");

  AST_DELAY_LOW: assert property (
    s.state == ST_DELAY |-> !sample_hold)
    else $error("hold pulse high during the start delay");

  AST_GAP_LOW: assert property (
    s.state == ST_GAP |-> !sample_hold)
    else $error("hold pulse high during the gap");

  AST_IDLE_LOW: assert property (
    s.state == ST_IDLE |-> !sample_hold)
    else $error("hold pulse high while idle");

  AST_LAST_PULSE: assert property (
    s.state == ST_HOLD && h && s.hcnt == 5'h00 && s.left == 4'h0 |=> s.state == ST_IDLE)
    else $error("sequencer went on after the last conversion");

  AST_FLAG_A_SOURCE: assert property (
    $rose(s.status[`ADCCT_ST_RES_A]) |-> $past(s.flag_a[`ADCCT_FLAG_DELAY-1]))
    else $error("result flag A set without a result write");

  AST_FLAG_B_SOURCE: assert property (
    $rose(s.status[`ADCCT_ST_RES_B]) |-> $past(s.flag_b[`ADCCT_FLAG_DELAY-1]))
    else $error("result flag B set without a result write");

  AST_SEQ_NO_B: assert property (
    !sampling_mode_select |-> !write_b)
    else $error("group B written in sequential mode");

  AST_PAIR_CHANNEL: assert property (
    sampling_mode_select |-> channel_select[3] == 1'b0)
    else $error("pair index above seven");

endmodule : adcct_ctrl

/* verif/tb_top.sv */
// self-checking bench for the converter control block
`include "adcct_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic [1:0]  event_manager_units = 2'h0;
  logic        external_start_conversion = 1'b0;
  logic [1:0]  bandgap_reference_enable;
  logic        converter_power_on;
  logic        converter_clock;
  logic        sample_hold;
  logic [3:0]  channel_select;
  logic        sampling_mode_select;
  logic [11:0] conv_data_a = 12'h000;
  logic [11:0] conv_data_b = 12'h000;
  logic        interrupt;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  adcct_ctrl i_dut (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .event_manager_units(event_manager_units),
    .external_start_conversion(external_start_conversion),
    .bandgap_reference_enable(bandgap_reference_enable),
    .converter_power_on(converter_power_on), .converter_clock(converter_clock),
    .sample_hold(sample_hold), .channel_select(channel_select),
    .sampling_mode_select(sampling_mode_select), .conv_data_a(conv_data_a),
    .conv_data_b(conv_data_b), .interrupt(interrupt)
  );

  // 40 MHz system clock
  always #12.5 clock = ~clock;

  task test_done;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // hang guard: the whole run needs a few thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle write strobe; returns at the edge that takes it
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rchk(input string what, input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(what, e, reg_rdata);
  endtask : rchk

  // cycles until the hold pulse reaches a level, 300 meaning never
  task till_sh(input logic lvl, output int n);
    n = 0;
    while (sample_hold !== lvl && n < 300) begin
      @(posedge clock);
      #1 n++;
    end
  endtask : till_sh

  // one-cycle trigger on source 0 (event A), 1 (event B) or 2 (external)
  task pulse(input int i);
    @(posedge clock);
    event_manager_units       <= (i == 0) ? 2'h1 : (i == 1) ? 2'h2 : 2'h0;
    external_start_conversion <= (i == 2);
    @(posedge clock);
    event_manager_units       <= 2'h0;
    external_start_conversion <= 1'b0;
  endtask : pulse

  task check_reset;
    #1 chk("out_rst", 16'h0000, {11'h000, sample_hold, interrupt, converter_power_on,
                                 bandgap_reference_enable});
    wr(4'h8, 16'hFFFF);
    wr(`ADCCT_OFS_RESULT_A, 16'h0FFF);
    for (int k = 0; k < 7; k++) begin
      rchk("reg_rst", (k < 5) ? 4'(k) : ((k == 5) ? 4'h8 : 4'hF), 16'h0000);
    end
    rchk("res_ro", `ADCCT_OFS_RESULT_A, 16'h0000);
  endtask : check_reset

  task power_cycle;
    int n;
    wr(`ADCCT_OFS_CTRL_THREE, 16'h00C0); // band-gap first
    // the block does not time the settle, so the wait is kept short here
    repeat (40) @(posedge clock);
    wr(`ADCCT_OFS_CTRL_THREE, 16'h00E0);
    #1 chk("bgref", 16'h0003, {14'h0000, bandgap_reference_enable});
    chk("power", 16'h0001, {15'h0000, converter_power_on});
    repeat (40) @(posedge clock);
    wr(`ADCCT_OFS_CTRL_THREE, 16'h0000);
    #1 chk("pwr_off", 16'h0000, {13'h0000, bandgap_reference_enable, converter_power_on});
    wr(`ADCCT_OFS_CTRL_TWO, 16'h8000);
    till_sh(1'b1, n);
    chk("start_off", 16'h012C, n[15:0]);
    rchk("ctrl2", `ADCCT_OFS_CTRL_TWO, 16'h0000);
  endtask : power_cycle

  // two conversions, timed against the hold pulse and the interrupt
  task run_conv(input logic mode, input logic [3:0] acq, input logic [3:0] chan);
    int n, t_irq, t_fall;
    logic prev;
    conv_data_a <= {acq, 4'h5, chan};
    conv_data_b <= {chan, acq, 4'hA};
    wr(`ADCCT_OFS_CTRL_THREE, {8'h00, 2'b11, 1'b1, 4'h0, mode});
    wr(`ADCCT_OFS_CTRL_ONE, {4'h0, acq, 4'h1, chan});
    wr(`ADCCT_OFS_STATUS, 16'h0007);
    wr(`ADCCT_OFS_MASK, {14'h0000, mode, ~mode});
    chk("mode", {15'h0000, mode}, {15'h0000, sampling_mode_select});
    chk("chan", {12'h000, mode ? {1'b0, chan[2:0]} : chan}, {12'h000, channel_select});
    wr(`ADCCT_OFS_CTRL_TWO, 16'h8000);
    till_sh(1'b1, n);
    chk("trig_delay", 16'h0005, n[15:0]);
    till_sh(1'b0, n);
    chk("hold_width", 16'(2 * (int'(acq) + 1)), n[15:0]);
    t_irq = 0;
    t_fall = 0;
    prev = 1'b0;
    // interrupt follows the masked result, second fall gives the period
    for (n = 1; n < 200; n++) begin
      @(posedge clock);
      #1;
      if (interrupt === 1'b1 && t_irq == 0) t_irq = n;
      if (prev === 1'b1 && sample_hold === 1'b0 && t_fall == 0) t_fall = n;
      prev = sample_hold;
    end
    chk("irq_delay", mode ? 16'h000C : 16'h000A, t_irq[15:0]);
    chk("period", 16'(2 * (int'(acq) + 2 + int'(mode))), t_fall[15:0]);
    rchk("res_a", `ADCCT_OFS_RESULT_A, {4'h0, acq, 4'h5, chan});
    if (mode) rchk("res_b", `ADCCT_OFS_RESULT_B, {4'h0, chan, acq, 4'hA});
    rchk("status", `ADCCT_OFS_STATUS, {14'h0000, mode, 1'b1});
    rchk("idle", `ADCCT_OFS_STATE, 16'h0000);
  endtask : run_conv

  task trig_sources;
    int n;
    wr(`ADCCT_OFS_CTRL_THREE, 16'h00E0);
    wr(`ADCCT_OFS_CTRL_ONE, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      wr(`ADCCT_OFS_CTRL_TWO, 16'(1 << i));
      pulse(i);
      till_sh(1'b1, n);
      chk("src_delay", 16'h0005, n[15:0]);
      repeat (40) @(posedge clock);
    end
    // event A with only the external source enabled must be ignored
    wr(`ADCCT_OFS_CTRL_TWO, 16'h0004);
    pulse(0);
    till_sh(1'b1, n);
    chk("src_off", 16'h012C, n[15:0]);
    // a second start while busy is refused and flagged
    wr(`ADCCT_OFS_STATUS, 16'h0007);
    wr(`ADCCT_OFS_MASK, 16'h0000);
    pulse(2);
    repeat (3) @(posedge clock);
    pulse(2);
    repeat (40) @(posedge clock);
    rchk("overrun", `ADCCT_OFS_STATUS, 16'h0005);
    #1 chk("irq_masked", 16'h0000, {15'h0000, interrupt});
    wr(`ADCCT_OFS_MASK, 16'h0004);
    #1 chk("irq_on", 16'h0001, {15'h0000, interrupt});
    wr(`ADCCT_OFS_STATUS, 16'h0004);
    #1 chk("irq_clr", 16'h0000, {15'h0000, interrupt});
    rchk("status_left", `ADCCT_OFS_STATUS, 16'h0001);
  endtask : trig_sources

  // divided converter clock: half period of two system clocks, hold pulse in ticks
  task clk_rate;
    int n;
    logic lvl;
    wr(`ADCCT_OFS_CTRL_THREE, 16'h00E2);
    repeat (4) @(posedge clock);
    n = 0;
    #1 lvl = converter_clock;
    while (converter_clock === lvl && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    lvl = converter_clock;
    n = 0;
    while (converter_clock === lvl && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    chk("half_period", 16'h0002, n[15:0]);
    wr(`ADCCT_OFS_CTRL_TWO, 16'h8000);
    till_sh(1'b1, n);
    till_sh(1'b0, n);
    chk("hold_div", 16'h0004, n[15:0]);
  endtask : clk_rate

  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check_reset();
    power_cycle();
    wr(`ADCCT_OFS_CTRL_THREE, 16'h00C0);
    repeat (40) @(posedge clock);
    wr(`ADCCT_OFS_CTRL_THREE, 16'h00E0);
    // the powered converter settles 20 us before the first start
    repeat (800) @(posedge clock);
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 3; k++) begin
        run_conv(m[0], (k == 0) ? 4'h0 : ((k == 1) ? 4'h3 : 4'hF), 4'hD);
      end
    end
    trig_sources();
    clk_rate();
    test_done();
  end

endmodule : tb_top
